/* src/eeprom_pkg.sv */
// Shared constants for the two-wire EEPROM target.
// Assumes a 10 MHz system clock sampling the bus pins.
package eeprom_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_HZ        = 10_000_000;
    localparam int TWR_US        = 5000;
    localparam int TWR_CYCLES    = TWR_US * (CLK_HZ / 1_000_000);

    // ==========================================================
    // Sizes
    localparam int ADDR_BITS     = 13;
    localparam int PAGE_BITS     = 5;
    localparam int PAGE_BYTES    = 32;
    localparam int ROW_BITS      = ADDR_BITS - PAGE_BITS;
    localparam int MEM_BYTES     = 8192;
    localparam int FIFO_DEPTH    = 2;

    // ==========================================================
    // Address byte fields
    localparam logic [3:0] TYPE_MAIN    = 4'hA;
    localparam logic [3:0] TYPE_SPECIAL = 4'hB;
    localparam int         WA0_SWP_BIT  = 7;
    localparam int         WA0_SEL_LSB  = 2;
    localparam logic [1:0] SEL_ID       = 2'h0;
    localparam logic [1:0] SEL_LOCK     = 2'h1;
    localparam logic [1:0] SEL_DSC      = 2'h3;
    localparam int         LOCK_DATA_BIT = 1;

    // ==========================================================
    // Write-protect register layout and reset values
    localparam int         WP_EN_BIT    = 3;
    localparam int         WP_SIZE_LSB  = 1;
    localparam int         WP_LOCK_BIT  = 0;
    localparam logic [7:0] WP_RESET     = 8'h00;
    localparam logic [2:0] DSC_RESET    = 3'h0;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [2:0] {CMD_NONE, CMD_MAIN, CMD_ID, CMD_LOCK, CMD_DSC, CMD_SWP} cmd_e;
    typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_WA0, ST_WA1, ST_DATA, ST_IGNORE} state_e;
endpackage

/* src/eeprom_target.sv */
// Two-wire bus target for a 64-Kbit EEPROM: write path, protection, select code.
// Assumes scl/sda arrive asynchronous and much slower than mclk_in (8 samples per bit or more).
// What this block does
// - Data-line change while clock high is a bus condition, never a data bit.
// - Data falling with clock high is start; start begins every command.
// - Data rising with clock high is stop; stop returns to standby.
// - Bytes are eight bits; acknowledge drives data low on the ninth clock.
// - Standby after power-up, after stop, and after the timed write ends.
// - Start, nine ones, start, stop leaves the target ready again.
// - Device byte: type 1010 or 1011, bits 3..1 equal the select code.
// - Device byte bit 0: one is read, zero is write.
// - Matching device byte is acknowledged; mismatch stays silent and idles.
// - Byte write: address, two word bytes, data, stop, then timed write.
// - Page write: further data bytes each acknowledged, ended by stop.
// - Only the low five address bits advance, wrapping within the page.
// - During the timed write the device byte is not acknowledged.
// - ID page write: type 1011, bits 11..10 zero, bits 4..0 pick byte.
// - Locked ID page: its data bytes get no acknowledge.
// - Type 1011, bits 11..10 = 01, data bit 1 set: locks ID page, select code.
// - Type 1010 with address bit 15 writes protect register; data 7..4 ignored.
// - More than one data byte discards a protect register write.
// - Protect register: enable bit 3, size 2..1, lock 0, upper zero, reset 00.
// - Size 00/01/10/11 protects from 1800/1000/0800/0000 to 1FFF.
// - Lock bit set freezes protect register bits 3..0.
// - Type 1011, bits 11..10 = 11 loads select code unless ID lock set.
`timescale 1ns/100ps
module eeprom_target
    import eeprom_pkg::*;
#(
    parameter int TWR_COUNT = TWR_CYCLES,
    parameter int BUF_DEPTH = FIFO_DEPTH
) (
    input  wire logic       mclk_in,
    input  wire logic       reset_n_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    output logic            busy_out,
    output logic [7:0]      protect_cfg_out,
    output logic [2:0]      select_code_out,
    output logic            id_lock_out
);
    localparam int CNT_W  = $clog2(TWR_COUNT + 1);
    localparam int ENT_W  = PAGE_BITS + 8;
    localparam int PTR_W  = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

    // ==========================================================
    // Pin synchronisers and bus conditions
    logic scl_meta_reg, scl_sync_reg, scl_prev_reg;
    logic sda_meta_reg, sda_sync_reg, sda_prev_reg;

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            scl_meta_reg <= 1'b1;
            scl_sync_reg <= 1'b1;
            scl_prev_reg <= 1'b1;
            sda_meta_reg <= 1'b1;
            sda_sync_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_meta_reg <= scl_in;
            scl_sync_reg <= scl_meta_reg;
            scl_prev_reg <= scl_sync_reg;
            sda_meta_reg <= sda_in;
            sda_sync_reg <= sda_meta_reg;
            sda_prev_reg <= sda_sync_reg;
        end
    end

    wire scl_rise  = scl_sync_reg & ~scl_prev_reg;
    wire scl_fall  = ~scl_sync_reg & scl_prev_reg;
    wire scl_high  = scl_sync_reg & scl_prev_reg;
    wire start_det = scl_high & sda_prev_reg & ~sda_sync_reg;
    wire stop_det  = scl_high & ~sda_prev_reg & sda_sync_reg;

    // ==========================================================
    // Nonvolatile cells: no reset, they keep their contents
    logic [3:0] wp_nv_reg   = WP_RESET[3:0];
    logic [2:0] dsc_nv_reg  = DSC_RESET;
    logic       lock_nv_reg = 1'b0;

    // ==========================================================
    // Byte receiver and acknowledge
    state_e            state_reg, state_next;
    cmd_e              cmd_reg;
    logic [7:0]        shift_reg;
    logic [3:0]        bit_cnt_reg;
    logic              byte_done_reg;
    logic              ack_reg;
    logic              ack_phase_reg;
    logic              special_reg;
    logic [7:0]        wa0_reg;
    logic [ROW_BITS-1:0]  row_reg;
    logic [PAGE_BITS-1:0] offset_reg;
    logic [7:0]        first_data_reg;
    logic [1:0]        data_cnt_reg;
    logic              busy_reg;

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            shift_reg     <= 8'h00;
            bit_cnt_reg   <= 4'h0;
            byte_done_reg <= 1'b0;
            ack_phase_reg <= 1'b0;
            sda_oe_out    <= 1'b0;
        end else begin
            byte_done_reg <= 1'b0;
            if (start_det || stop_det) begin
                bit_cnt_reg   <= 4'h0;
                ack_phase_reg <= 1'b0;
                sda_oe_out    <= 1'b0;
            end else if (scl_rise && bit_cnt_reg < BITS_PER_BYTE) begin
                shift_reg     <= {shift_reg[6:0], sda_sync_reg};
                bit_cnt_reg   <= bit_cnt_reg + 4'h1;
                byte_done_reg <= (bit_cnt_reg == BITS_PER_BYTE - 4'h1);
            end else if (scl_fall && bit_cnt_reg == BITS_PER_BYTE) begin
                if (!ack_phase_reg) begin
                    ack_phase_reg <= 1'b1;
                    sda_oe_out    <= ack_reg;
                end else begin
                    ack_phase_reg <= 1'b0;
                    sda_oe_out    <= 1'b0;
                    bit_cnt_reg   <= 4'h0;
                end
            end
        end
    end

    // ==========================================================
    // Command decode
    wire       dev_type_ok = (shift_reg[7:4] == TYPE_MAIN) || (shift_reg[7:4] == TYPE_SPECIAL);
    wire       dev_match   = dev_type_ok && (shift_reg[3:1] == dsc_nv_reg) && !busy_reg;
    wire       dev_read    = shift_reg[0];
    wire [1:0] wa_sel      = wa0_reg[WA0_SEL_LSB +: 2];
    wire       in_data     = byte_done_reg && (state_reg == ST_DATA);
    wire       use_fifo    = (cmd_reg == CMD_MAIN) || (cmd_reg == CMD_ID);
    wire       id_refused  = (cmd_reg == CMD_ID) && lock_nv_reg;
    wire       fifo_in_valid;
    wire       fifo_in_ready;

    cmd_e cmd_decode;
    always_comb begin
        cmd_decode = CMD_NONE;
        if (!special_reg) begin
            cmd_decode = wa0_reg[WA0_SWP_BIT] ? CMD_SWP : CMD_MAIN;
        end else begin
            case (wa_sel)
                SEL_ID:   cmd_decode = CMD_ID;
                SEL_LOCK: cmd_decode = CMD_LOCK;
                SEL_DSC:  cmd_decode = CMD_DSC;
                default:  cmd_decode = CMD_NONE;
            endcase
        end
    end

    always_comb begin
        state_next = state_reg;
        if (start_det) begin
            state_next = ST_DEV;
        end else if (stop_det) begin
            state_next = ST_IDLE;
        end else if (byte_done_reg) begin
            case (state_reg)
                ST_DEV:  state_next = (dev_match && !dev_read) ? ST_WA0 : ST_IGNORE;
                ST_WA0:  state_next = ST_WA1;
                ST_WA1:  state_next = ST_DATA;
                ST_DATA: state_next = ST_DATA;
                default: state_next = state_reg;
            endcase
        end
    end

    wire go_write = stop_det && (state_reg == ST_DATA) && (data_cnt_reg != 2'h0);

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg      <= ST_IDLE;
            cmd_reg        <= CMD_NONE;
            ack_reg        <= 1'b0;
            special_reg    <= 1'b0;
            wa0_reg        <= 8'h00;
            row_reg        <= '0;
            offset_reg     <= '0;
            first_data_reg <= 8'h00;
            data_cnt_reg   <= 2'h0;
        end else begin
            state_reg <= state_next;
            if (start_det) begin
                data_cnt_reg <= 2'h0;
            end else if (byte_done_reg) begin
                ack_reg <= 1'b0;
                case (state_reg)
                    ST_DEV: begin
                        ack_reg     <= dev_match;
                        special_reg <= (shift_reg[7:4] == TYPE_SPECIAL);
                    end
                    ST_WA0: begin
                        ack_reg <= 1'b1;
                        wa0_reg <= shift_reg;
                    end
                    ST_WA1: begin
                        ack_reg    <= 1'b1;
                        cmd_reg    <= cmd_decode;
                        row_reg    <= {wa0_reg[4:0], shift_reg[7:PAGE_BITS]};
                        offset_reg <= shift_reg[PAGE_BITS-1:0];
                    end
                    ST_DATA: begin
                        ack_reg <= !id_refused && (!use_fifo || fifo_in_ready);
                        if (!id_refused && (!use_fifo || fifo_in_ready)) begin
                            offset_reg <= offset_reg + 1'b1;
                            if (data_cnt_reg == 2'h0) begin
                                first_data_reg <= shift_reg;
                            end
                            if (data_cnt_reg != 2'h2) begin
                                data_cnt_reg <= data_cnt_reg + 2'h1;
                            end
                        end
                    end
                    default: ack_reg <= 1'b0;
                endcase
            end
        end
    end

    // ==========================================================
    // Two-entry buffer between receiver and page latch
    // A full buffer answers with no acknowledge, so no byte is ever lost silently.
    logic [ENT_W-1:0] fifo_mem [BUF_DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg, rd_ptr_reg;
    logic [PTR_W:0]   fifo_cnt_reg;

    assign fifo_in_valid = in_data && use_fifo && !id_refused;
    assign fifo_in_ready = (fifo_cnt_reg != (PTR_W + 1)'(BUF_DEPTH));
    wire   fifo_out_valid = (fifo_cnt_reg != '0);
    wire   fifo_out_ready = !busy_reg;
    wire   fifo_push      = fifo_in_valid && fifo_in_ready;
    wire   fifo_pop       = fifo_out_valid && fifo_out_ready;
    wire [ENT_W-1:0] fifo_head = fifo_mem[rd_ptr_reg];

    always_ff @(posedge mclk_in) begin
        if (fifo_push) begin
            fifo_mem[wr_ptr_reg] <= {offset_reg, shift_reg};
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_ptr_reg   <= '0;
            rd_ptr_reg   <= '0;
            fifo_cnt_reg <= '0;
        end else begin
            if (fifo_push) begin
                wr_ptr_reg <= (wr_ptr_reg == PTR_W'(BUF_DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (fifo_pop) begin
                rd_ptr_reg <= (rd_ptr_reg == PTR_W'(BUF_DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            fifo_cnt_reg <= fifo_cnt_reg + (PTR_W + 1)'(fifo_push) - (PTR_W + 1)'(fifo_pop);
        end
    end

    // ==========================================================
    // Page latch: later bytes at the same offset overwrite earlier ones
    logic [7:0]            page_data [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] page_valid;
    wire                   latch_clr = start_det && !busy_reg;

    genvar gi;
    generate
        for (gi = 0; gi < PAGE_BYTES; gi++) begin : g_page
            always_ff @(posedge mclk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    page_valid[gi] <= 1'b0;
                    page_data[gi]  <= 8'h00;
                end else if (latch_clr) begin
                    page_valid[gi] <= 1'b0;
                end else if (fifo_pop && fifo_head[ENT_W-1:8] == PAGE_BITS'(gi)) begin
                    page_valid[gi] <= 1'b1;
                    page_data[gi]  <= fifo_head[7:0];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Self-timed write cycle
    logic [CNT_W-1:0]   busy_cnt_reg;
    logic [PAGE_BITS:0] commit_idx_reg;

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            busy_reg       <= 1'b0;
            busy_cnt_reg   <= '0;
            commit_idx_reg <= '0;
        end else if (go_write) begin
            busy_reg       <= 1'b1;
            busy_cnt_reg   <= CNT_W'(TWR_COUNT - 1);
            commit_idx_reg <= '0;
        end else if (busy_reg) begin
            if (commit_idx_reg != (PAGE_BITS + 1)'(PAGE_BYTES)) begin
                commit_idx_reg <= commit_idx_reg + 1'b1;
            end
            busy_cnt_reg <= busy_cnt_reg - 1'b1;
            busy_reg     <= (busy_cnt_reg != '0);
        end
    end

    wire [PAGE_BITS-1:0] c_off       = commit_idx_reg[PAGE_BITS-1:0];
    wire [ADDR_BITS-1:0] commit_addr = {row_reg, c_off};
    wire                 committing  = busy_reg && !commit_idx_reg[PAGE_BITS] && page_valid[c_off];
    // Protected from base upward: the two top address bits reach the inverted size code
    wire                 in_protect  = wp_nv_reg[WP_EN_BIT]
                                       && (commit_addr[ADDR_BITS-1 -: 2] >= ~wp_nv_reg[WP_SIZE_LSB +: 2]);
    wire                 mem_we      = committing && (cmd_reg == CMD_MAIN) && !in_protect;
    wire                 id_we       = committing && (cmd_reg == CMD_ID) && !lock_nv_reg;

    // ==========================================================
    // Storage arrays
    logic [7:0] mem_array [MEM_BYTES];
    logic [7:0] id_page   [PAGE_BYTES];

    always_ff @(posedge mclk_in) begin
        if (mem_we) begin
            mem_array[commit_addr] <= page_data[c_off];
        end
        if (id_we) begin
            id_page[c_off] <= page_data[c_off];
        end
    end

    // ==========================================================
    // Configuration cells, committed at the stop that ends the command
    wire swp_ok  = go_write && (cmd_reg == CMD_SWP) && (data_cnt_reg == 2'h1)
                   && !wp_nv_reg[WP_LOCK_BIT];
    wire lock_ok = go_write && (cmd_reg == CMD_LOCK) && first_data_reg[LOCK_DATA_BIT];
    wire dsc_ok  = go_write && (cmd_reg == CMD_DSC) && !lock_nv_reg;

    always_ff @(posedge mclk_in) begin
        if (swp_ok) begin
            wp_nv_reg <= first_data_reg[3:0];
        end
        if (lock_ok) begin
            lock_nv_reg <= 1'b1;
        end
        if (dsc_ok) begin
            dsc_nv_reg <= first_data_reg[2:0];
        end
    end

    // ==========================================================
    // Status outputs
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sda_out         <= 1'b0;
            busy_out        <= 1'b0;
            protect_cfg_out <= WP_RESET;
            select_code_out <= DSC_RESET;
            id_lock_out     <= 1'b0;
        end else begin
            sda_out         <= 1'b0;
            busy_out        <= busy_reg;
            protect_cfg_out <= {4'h0, wp_nv_reg};
            select_code_out <= dsc_nv_reg;
            id_lock_out     <= lock_nv_reg;
        end
    end
endmodule

/* testbench/eeprom_target_chk.sv */
// Port checker for the EEPROM target.
// Assumes a bind onto eeprom_target and a single clock domain.
`timescale 1ns/100ps
module eeprom_target_chk #(
    parameter int TWR_COUNT = 200
) (
    input wire logic       mclk_in,
    input wire logic       reset_n_in,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe_out,
    input wire logic       busy_out,
    input wire logic [7:0] protect_cfg_out,
    input wire logic [2:0] select_code_out,
    input wire logic       id_lock_out
);
    // ==========================================================
    // Busy length counter, too long for a repetition
    int busy_cnt_reg;
    int busy_cnt_next;
    assign busy_cnt_next = busy_out ? busy_cnt_reg + 1 : 0;
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in)
            busy_cnt_reg <= 0;
        else
            busy_cnt_reg <= busy_cnt_next;
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    // ==========================================================
    // Properties
    sequence bus_idle;
        scl_in && sda_in;
    endsequence
    sequence busy_soon;
        bus_idle ##[0:2] busy_out;
    endsequence
    drive_zero_a: assert property (sda_out == 1'b0)
        else $error("sda drive not zero");
    ack_low_phase_a: assert property ($changed(sda_oe_out) |-> !$past(scl_in))
        else $error("ack moved with clock high");
    ack_holds_a: assert property (sda_oe_out && $rose(scl_in) |-> sda_oe_out [*4])
        else $error("ack dropped in clock high");
    busy_noack_a: assert property (busy_out |-> !sda_oe_out)
        else $error("ack while busy");
    busy_after_stop_a: assert property ($rose(busy_out) |-> bus_idle)
        else $error("busy without stop");
    busy_len_a: assert property ($fell(busy_out) |-> busy_cnt_reg == TWR_COUNT)
        else $error("write time wrong");
    cfg_on_write_a: assert property ($past(reset_n_in, 3) && $changed(protect_cfg_out) |-> busy_soon)
        else $error("protect change outside write");
    wp_upper_zero_a: assert property (protect_cfg_out[7:4] == 4'h0)
        else $error("protect upper bits set");
    wp_frozen_a: assert property ($past(reset_n_in, 3) && $past(protect_cfg_out[0]) |-> $stable(protect_cfg_out[3:0]))
        else $error("locked protect changed");
    id_lock_keep_a: assert property ($past(reset_n_in, 3) && $past(id_lock_out) |-> id_lock_out && $stable(select_code_out))
        else $error("locked select code changed");
endmodule

bind eeprom_target eeprom_target_chk #(.TWR_COUNT(TWR_COUNT)) i_chk (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .busy_out(busy_out),
    .protect_cfg_out(protect_cfg_out), .select_code_out(select_code_out), .id_lock_out(id_lock_out)
);

/* testbench/bus_master_model.sv */
// Two-wire bus master model: drives the bus clock and pulls the data line.
// Assumes a pull-up on the data wire resolved by the bench; moves on mclk falling edges.
`timescale 1ns/100ps
module bus_master_model (
    input  wire logic mclk_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_oe_out
);
    // Clock stands high between frames
    initial begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end
    task automatic ticks(input int n);
        repeat (n) @(negedge mclk_in);
    endtask
    // Data moves only in the low phase; 8 cycles make an 800 ns bit
    task automatic put_bit(input logic b, output logic seen);
        ticks(2);
        sda_oe_out = !b;
        ticks(2);
        scl_out = 1'b1;
        ticks(2);
        seen = sda_in;
        ticks(2);
        scl_out = 1'b0;
    endtask
    // Also serves as repeated start from a low clock
    task automatic start();
        ticks(2);
        sda_oe_out = 1'b0;
        ticks(2);
        scl_out = 1'b1;
        ticks(4);
        sda_oe_out = 1'b1;
        ticks(4);
        scl_out = 1'b0;
    endtask
    task automatic stop();
        ticks(2);
        sda_oe_out = 1'b1;
        ticks(2);
        scl_out = 1'b1;
        ticks(4);
        sda_oe_out = 1'b0;
        ticks(4);
    endtask
    // MSB first, then a released ninth bit; ack is a low seen there
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            put_bit(b[i], s);
        put_bit(1'b1, s);
        ack = !s;
    endtask
endmodule

/* testbench/serial_eeprom_i2c_target_tb.sv */
// Self-checking bench for the EEPROM target write path.
// Assumes the bus master model and the bound port checker.
`timescale 1ns/100ps
module serial_eeprom_i2c_target_tb;
    import eeprom_pkg::*;
    localparam int TWR_SIM = 200;
    logic       mclk_in;
    logic       reset_n_in;
    logic       scl;
    logic       m_oe;
    logic       d_sda;
    logic       d_oe;
    logic       sda_wire;
    logic       busy;
    logic [7:0] cfg;
    logic [2:0] sel;
    logic       lock;
    logic [7:0] acks;
    int         mismatches = 0;
    int         samples_checked = 0;
    // Open-drain wire with pull-up
    assign sda_wire = !(m_oe || (d_oe && !d_sda));
    eeprom_target #(.TWR_COUNT(TWR_SIM)) i_dut (
        .mclk_in(mclk_in), .reset_n_in(reset_n_in), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(d_sda), .sda_oe_out(d_oe), .busy_out(busy),
        .protect_cfg_out(cfg), .select_code_out(sel), .id_lock_out(lock)
    );
    bus_master_model i_master (.mclk_in(mclk_in), .sda_in(sda_wire), .scl_out(scl), .sda_oe_out(m_oe));
    initial begin
        mclk_in = 1'b0;
        forever #50 mclk_in = !mclk_in;
    end
    // ==========================================================
    // Shared tasks
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic send(input logic [7:0] q[$]);
        logic a;
        acks = 8'h00;
        i_master.start();
        foreach (q[i]) begin
            i_master.put_byte(q[i], a);
            acks[i] = a;
        end
        i_master.stop();
    endtask
    task automatic settle();
        i_master.ticks(4);
        for (int i = 0; i < TWR_SIM + 20 && busy !== 1'b0; i++)
            i_master.ticks(1);
        check({7'h00, busy}, 8'h00, "busy stuck");
    endtask
    task automatic end_sim();
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic s_addressing();
        check(cfg, 8'h00, "protect reset");
        send('{8'hA2});
        check(acks, 8'h00, "foreign select");
        send('{8'hA1});
        check(acks, 8'h01, "read address acked");
    endtask
    task automatic s_write_poll();
        send('{8'hA0, 8'h00, 8'h10, 8'h55});
        check(acks, 8'h0F, "byte write acks");
        i_master.ticks(3);
        check({7'h00, busy}, 8'h01, "busy after stop");
        send('{8'hA0});
        check(acks, 8'h00, "poll while busy");
        settle();
        check(i_dut.mem_array[13'h0010], 8'h55, "byte write data");
        send('{8'hA0});
        check(acks, 8'h01, "poll after write");
        send('{8'hA0, 8'h01, 8'hFE, 8'h11, 8'h22, 8'h33});
        check(acks, 8'h3F, "page write acks");
        settle();
        check(i_dut.mem_array[13'h01E0], 8'h33, "page wrap");
    endtask
    task automatic s_protect();
        send('{8'hA0, 8'h80, 8'h00, 8'hFE});
        settle();
        check(cfg, 8'h0E, "protect write");
        send('{8'hA0, 8'h00, 8'h10, 8'hAA});
        settle();
        check(i_dut.mem_array[13'h0010], 8'h55, "protected byte kept");
        send('{8'hA0, 8'h80, 8'h00, 8'h01, 8'h02});
        settle();
        check(cfg, 8'h0E, "protect two bytes");
        send('{8'hA0, 8'h80, 8'h00, 8'h0B});
        settle();
        send('{8'hA0, 8'h80, 8'h00, 8'h00});
        settle();
        check(cfg, 8'h0B, "protect locked");
    endtask
    task automatic s_select();
        send('{8'hB0, 8'h0C, 8'h00, 8'h05});
        settle();
        check({5'h00, sel}, 8'h05, "select load");
        send('{8'hA0});
        check(acks, 8'h00, "old select");
        send('{8'hBA, 8'h00, 8'h03, 8'h77, 8'h88});
        check(acks, 8'h1F, "id page write");
        settle();
        check(i_dut.id_page[4], 8'h88, "id page data");
        send('{8'hBA, 8'h04, 8'h00, 8'h02});
        settle();
        check({7'h00, lock}, 8'h01, "id lock");
        send('{8'hBA, 8'h00, 8'h03, 8'h99});
        check(acks, 8'h07, "locked id data");
        settle();
        check(i_dut.id_page[3], 8'h77, "locked id kept");
        send('{8'hBA, 8'h0C, 8'h00, 8'h01});
        settle();
        check({5'h00, sel}, 8'h05, "select frozen");
    endtask
    task automatic s_soft_reset();
        logic a;
        i_master.start();
        i_master.put_byte(8'hAA, a);
        i_master.put_byte(8'h00, a);
        i_master.start();
        i_master.put_byte(8'hFF, a);
        i_master.start();
        i_master.stop();
        send('{8'hAA});
        check(acks, 8'h01, "ready after recovery");
    endtask
    task automatic s_retention();
        reset_n_in = 1'b0;
        i_master.ticks(4);
        reset_n_in = 1'b1;
        i_master.ticks(4);
        check(cfg, 8'h0B, "protect kept");
        check({4'h0, lock, sel}, 8'h0D, "select and lock kept");
    endtask
    initial begin
        reset_n_in = 1'b0;
        repeat (4) @(negedge mclk_in);
        reset_n_in = 1'b1;
        i_master.ticks(4);
        s_addressing();
        s_write_poll();
        s_protect();
        s_select();
        s_soft_reset();
        s_retention();
        end_sim();
    end
    // About six times the expected run
    initial begin
        #4_000_000;
        mismatches++;
        end_sim();
    end
endmodule
